// *** rtl/fsp_pkg.sv ***
// constants and types for the fifo serial port
package fsp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] FCR_OFS  = 8'h08;
  localparam logic [7:0] CNT_OFS  = 8'h0C;
  localparam logic [7:0] TXD_OFS  = 8'h10;
  localparam logic [7:0] RXD_OFS  = 8'h14;
  localparam logic [7:0] PORT_OFS = 8'h18;
  localparam logic [7:0] LINE_OFS = 8'h1C;
  localparam logic [7:0] BAUD_OFS = 8'h20;
  localparam logic [7:0] IVEC_OFS = 8'h24;
  // serial_control_reg fields
  localparam int TIE_B = 7, RIE_B = 6, TXEN_B = 5, RXEN_B = 4, RX_ERROR_IRQ_ENABLE_B = 3, SYNC_B = 0;
  // serial_status_reg fields
  localparam int ERRF_B = 7, TEND_B = 6, TX_FIFO_EMPTY_FLAG_B = 5, BRKF_B = 4, FERF_B = 3;
  localparam int RDF_B = 1, RDY_B = 0;
  // fifo_control_reg fields
  localparam int RTRG_B = 6, TTRG_B = 4, TFRST_B = 2, RFRST_B = 1;
  // serial_port_reg fields, then the line register overrun bit
  localparam int RTSOE_B = 5, RTSLV_B = 4, TXOE_B = 1, TXLV_B = 0;
  localparam int OVR_B = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FCR_RST  = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // fifo and sampling figures
  localparam int          DEPTH      = 16;
  localparam logic [3:0]  MID_TICK   = 4'h7;  // eighth base pulse
  localparam logic [3:0]  LAST_TICK  = 4'hF;  // sixteen pulses a bit
  localparam logic [7:0]  RDY_TICKS  = 8'hF0; // idle time before data ready
  // trigger levels
  localparam logic [4:0] TTRG_0 = 5'h08, TTRG_1 = 5'h04, TTRG_2 = 5'h02, TTRG_3 = 5'h00;
  localparam logic [4:0] RTRG_0 = 5'h01, RTRG_1 = 5'h04, RTRG_2 = 5'h08, RTRG_3 = 5'h0E;
  // interrupt vector codes, lower code is higher priority
  localparam logic [2:0] IV_NONE = 3'h0, IV_ERR = 3'h1, IV_RXF = 3'h2;
  localparam logic [2:0] IV_BRK = 3'h3, IV_TXE = 3'h4;
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } fsp_aphase_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_START = 2'b01, ST_DATA = 2'b10, ST_STOP = 2'b11
  } fsp_state_type;
endpackage

// *** rtl/fsp_top.sv ***
// fifo serial port: ahb-lite registers, fifos, async tx/rx, flags and irq lines
`timescale 1ns/1ns
// Behaviour
// - four sources, each on its own request line
// - tx empty request when tx irq enable and tx fifo empty flag
// - rx full request when rx irq enable and full or ready flag
// - ready flag feeds rx full request only in async mode
// - break request when either rx enable and break or overrun flag
// - rx error request when either rx enable and rx error flag
// - rx enable off, error enable on: error and break, never full
// - priority error, full, break, tx empty; vector register shows it
// - tx empty flag sets when tx count at or below trigger
// - clearing tx empty flag while count low sets it again
// - count register: tx count high byte, rx count low byte
// - rx full flag sets when rx count reaches trigger
// - clearing rx full flag while count high sets it again
// - break sets framing error, stops fifo writes, receiver runs on
// - txd direction and level follow port bits while tx disabled
// - clearing tx enable resets transmitter at once, pin shows level bit
// - base tick at 16x bit rate, resync on start falling edge
// - bits latched on the eighth base pulse, mid bit
// - txd and rts float while tx disabled unless port bits drive
// - start bit goes out right after tx enable is set
module fsp_top
  import fsp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             txd_oe,
  output logic             rts_o,
  output logic             rts_oe,
  output logic             tx_empty_irq,
  output logic             rx_error_irq,
  output logic             rx_full_irq,
  output logic             break_irq
);
  function automatic logic [3:0] inc4(input logic [3:0] v);
    return 4'(v + 4'h1);
  endfunction

  fsp_aphase_type ap_q;
  logic [7:0]  ctrl_q, fcr_q, port_q, baud_q, baud_cnt_q, rdy_cnt_q, hrd_d;
  logic [7:0]  tx_mem [DEPTH];
  logic [7:0]  rx_mem [DEPTH];
  logic [3:0]  tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q, tx_sub_q, rx_sub_q;
  logic [4:0]  tx_cnt_q, rx_cnt_q, tx_thr, rx_thr;
  logic [2:0]  tx_bit_q, rx_bit_q, ivec_q;
  logic [8:0]  tx_sh_q;
  logic [7:0]  rx_sh_q;
  fsp_state_type tx_st_q, rx_st_q;
  logic        tick, acc, rd_acc, wr, tx_en, rx_push, rx_pop, tx_push, tx_pop;
  logic        tx_line_q, rx_s1_q, rx_s2_q, rx_prev_q, in_brk_q, frame_done;
  logic        err_q, tend_q, tx_fifo_empty_flag_q, brk_q, fer_q, rdf_q, rdy_q, ovr_q;
  logic        hrdy_q, hresp_q;
  logic [15:0] hrd_q, cnt_rd;

  // read data flop is cleared outside a read data phase
  assign hrdata    = {16'h0000, hrd_q};
  assign hreadyout = hrdy_q;
  assign hresp     = hresp_q;

  // bus address phase decode
  assign acc    = hsel & htrans[1] & hready;
  assign rd_acc = acc & ~hwrite;
  assign wr     = ap_q.valid & ap_q.write;
  assign tx_en  = ctrl_q[TXEN_B];
  assign tick   = (baud_cnt_q == baud_q);

  // trigger level decode
  always_comb begin
    unique case (fcr_q[TTRG_B +: 2])
      2'b00: tx_thr = TTRG_0;
      2'b01: tx_thr = TTRG_1;
      2'b10: tx_thr = TTRG_2;
      2'b11: tx_thr = TTRG_3;
    endcase
    unique case (fcr_q[RTRG_B +: 2])
      2'b00: rx_thr = RTRG_0;
      2'b01: rx_thr = RTRG_1;
      2'b10: rx_thr = RTRG_2;
      2'b11: rx_thr = RTRG_3;
    endcase
  end

  // read data mux, taken in the address phase
  always_comb begin
    hrd_d = 8'h00;
    unique case (haddr[7:0])
      CTRL_OFS: hrd_d = ctrl_q;
      STAT_OFS: hrd_d = {err_q, tend_q, tx_fifo_empty_flag_q, brk_q, fer_q, 1'b0, rdf_q, rdy_q};
      FCR_OFS:  hrd_d = fcr_q;
      RXD_OFS:  hrd_d = rx_mem[rx_rp_q];
      PORT_OFS: hrd_d = port_q;
      LINE_OFS: hrd_d = {7'h00, ovr_q};
      BAUD_OFS: hrd_d = baud_q;
      IVEC_OFS: hrd_d = {5'h00, ivec_q};
      default:  hrd_d = 8'h00;
    endcase
  end

  // bus slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q    <= '0;
      hrd_q   <= 16'h0000;
      hrdy_q  <= 1'b0;
      hresp_q <= 1'b0;
    end else begin
      hrdy_q  <= 1'b1;
      hresp_q <= 1'b0;
      if (hready) begin
        ap_q <= '{addr: haddr[7:0], write: hwrite, valid: acc};
      end
      if (rd_acc) begin
        hrd_q <= (haddr[7:0] == CNT_OFS) ? cnt_rd : {8'h00, hrd_d};
      end else if (hready) begin
        hrd_q <= 16'h0000; // stands in the data phase only
      end
    end
  end

  // count register is 16 bits, read apart from the byte mux
  assign cnt_rd = {3'h0, tx_cnt_q, 3'h0, rx_cnt_q};

  // software control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
      fcr_q  <= FCR_RST;
      port_q <= PORT_RST;
      baud_q <= BAUD_RST;
    end else if (wr) begin
      if (ap_q.addr == CTRL_OFS) ctrl_q <= hwdata[7:0];
      if (ap_q.addr == FCR_OFS)  fcr_q  <= hwdata[7:0];
      if (ap_q.addr == PORT_OFS) port_q <= hwdata[7:0];
      if (ap_q.addr == BAUD_OFS) baud_q <= hwdata[7:0];
    end
  end

  // base clock at sixteen times the bit rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt_q <= 8'h00;
    end else begin
      baud_cnt_q <= tick ? 8'h00 : 8'(baud_cnt_q + 8'h01);
    end
  end

  // transmit fifo
  assign tx_push = wr && ap_q.addr == TXD_OFS && tx_cnt_q != 5'(DEPTH);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp_q  <= 4'h0;
      tx_rp_q  <= 4'h0;
      tx_cnt_q <= 5'h00;
    end else if (fcr_q[TFRST_B]) begin
      tx_wp_q  <= 4'h0;
      tx_rp_q  <= 4'h0;
      tx_cnt_q <= 5'h00;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_q] <= hwdata[7:0];
        tx_wp_q         <= inc4(tx_wp_q);
      end
      if (tx_pop) tx_rp_q <= inc4(tx_rp_q);
      tx_cnt_q <= 5'(tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop});
    end
  end

  // transmitter: 8n1, reset whenever tx enable is low
  assign tx_pop = tx_en && tx_st_q == ST_IDLE && tx_cnt_q != 5'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q   <= ST_IDLE;
      tx_sub_q  <= 4'h0;
      tx_bit_q  <= 3'h0;
      tx_sh_q   <= 9'h1FF;
      tx_line_q <= 1'b1;
      tend_q    <= 1'b1;
    end else if (!tx_en) begin
      tx_st_q   <= ST_IDLE;
      tx_line_q <= 1'b1;
      tend_q    <= 1'b1;
    end else begin
      unique case (tx_st_q)
        ST_IDLE: if (tx_pop) begin
          tx_st_q   <= ST_START;
          tx_sh_q   <= {1'b1, tx_mem[tx_rp_q]};
          tx_line_q <= 1'b0;
          tx_sub_q  <= 4'h0;
          tend_q    <= 1'b0;
        end else begin
          tend_q <= 1'b1;
        end
        ST_START, ST_DATA, ST_STOP: if (tick) begin
          tx_sub_q <= inc4(tx_sub_q);
          if (tx_sub_q == LAST_TICK) begin
            tx_line_q <= tx_sh_q[0];
            tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
            tx_bit_q  <= 3'(tx_bit_q + 3'h1);
            if (tx_st_q == ST_START) begin
              tx_st_q  <= ST_DATA;
              tx_bit_q <= 3'h0;
            end else if (tx_st_q == ST_DATA && tx_bit_q == 3'h7) begin
              tx_st_q <= ST_STOP;
            end else if (tx_st_q == ST_STOP) begin
              tx_st_q   <= ST_IDLE;
              tx_line_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // pins: port bits rule the pin while the transmitter is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_o  <= 1'b1;
      txd_oe <= 1'b0;
      rts_o  <= 1'b1;
      rts_oe <= 1'b0;
    end else begin
      txd_o  <= tx_en ? tx_line_q : port_q[TXLV_B];
      txd_oe <= tx_en | port_q[TXOE_B];
      rts_o  <= tx_en ? (rx_cnt_q == 5'(DEPTH)) : port_q[RTSLV_B];
      rts_oe <= tx_en | port_q[RTSOE_B];
    end
  end

  // receive line synchroniser and base-tick sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd_i;
      rx_s2_q <= rx_s1_q;
      if (tick) rx_prev_q <= rx_s2_q;
    end
  end

  // receiver: resync on start edge, sample on mid pulse
  assign frame_done = rx_st_q == ST_STOP && tick && rx_sub_q == LAST_TICK;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q  <= ST_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q  <= 8'h00;
    end else if (!ctrl_q[RXEN_B]) begin
      rx_st_q <= ST_IDLE;
    end else if (tick) begin
      rx_sub_q <= inc4(rx_sub_q);
      unique case (rx_st_q)
        ST_IDLE: if (rx_prev_q && !rx_s2_q) begin
          rx_st_q  <= ST_START;
          rx_sub_q <= 4'h1;
        end
        ST_START: if (rx_sub_q == MID_TICK) begin
          rx_st_q  <= rx_s2_q ? ST_IDLE : ST_DATA;
          rx_sub_q <= 4'h0;
          rx_bit_q <= 3'h0;
        end
        ST_DATA: if (rx_sub_q == LAST_TICK) begin
          rx_sh_q  <= {rx_s2_q, rx_sh_q[7:1]};
          rx_bit_q <= 3'(rx_bit_q + 3'h1);
          if (rx_bit_q == 3'h7) rx_st_q <= ST_STOP;
        end
        ST_STOP: if (rx_sub_q == LAST_TICK) begin
          rx_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // receive fifo: no write during break or pending overrun
  assign rx_push = frame_done && !in_brk_q && !brk_q && !ovr_q && rx_s2_q
                   && rx_cnt_q != 5'(DEPTH);
  assign rx_pop  = rd_acc && haddr[7:0] == RXD_OFS && rx_cnt_q != 5'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_q  <= 4'h0;
      rx_rp_q  <= 4'h0;
      rx_cnt_q <= 5'h00;
    end else if (fcr_q[RFRST_B]) begin
      rx_wp_q  <= 4'h0;
      rx_rp_q  <= 4'h0;
      rx_cnt_q <= 5'h00;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_q] <= rx_sh_q;
        rx_wp_q         <= inc4(rx_wp_q);
      end
      if (rx_pop) rx_rp_q <= inc4(rx_rp_q);
      rx_cnt_q <= 5'(rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop});
    end
  end

  // data ready: rx fifo below trigger and line idle long enough
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_cnt_q <= 8'h00;
    end else if (rx_st_q != ST_IDLE || rx_push || rx_pop || rx_cnt_q == 5'h00) begin
      rdy_cnt_q <= 8'h00;
    end else if (tick && rdy_cnt_q != RDY_TICKS) begin
      rdy_cnt_q <= 8'(rdy_cnt_q + 8'h01);
    end
  end

  // status flags: hardware set wins over a software zero write
  logic st_wr, ln_wr;
  assign st_wr = wr && ap_q.addr == STAT_OFS;
  assign ln_wr = wr && ap_q.addr == LINE_OFS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_q    <= 1'b0;
      tx_fifo_empty_flag_q   <= 1'b0;
      brk_q    <= 1'b0;
      fer_q    <= 1'b0;
      rdf_q    <= 1'b0;
      rdy_q    <= 1'b0;
      ovr_q    <= 1'b0;
      in_brk_q <= 1'b0;
    end else begin
      tx_fifo_empty_flag_q <= (tx_cnt_q <= tx_thr) | (tx_fifo_empty_flag_q & ~(st_wr & ~hwdata[TX_FIFO_EMPTY_FLAG_B]));
      rdf_q  <= (rx_cnt_q >= rx_thr) | (rdf_q & ~(st_wr & ~hwdata[RDF_B]));
      rdy_q  <= (rdy_cnt_q == RDY_TICKS && rx_cnt_q < rx_thr)
                | (rdy_q & ~(st_wr & ~hwdata[RDY_B]));
      fer_q  <= (frame_done & ~rx_s2_q) | (fer_q & ~(st_wr & ~hwdata[FERF_B]));
      err_q  <= (frame_done & ~rx_s2_q) | (err_q & ~(st_wr & ~hwdata[ERRF_B]));
      brk_q  <= (frame_done & ~rx_s2_q & rx_sh_q == 8'h00)
                | (brk_q & ~(st_wr & ~hwdata[BRKF_B]));
      ovr_q  <= (frame_done & rx_s2_q & rx_cnt_q == 5'(DEPTH))
                | (ovr_q & ~(ln_wr & ~hwdata[OVR_B]));
      if (frame_done && !rx_s2_q && rx_sh_q == 8'h00) begin
        in_brk_q <= 1'b1;
      end else if (rx_s2_q) begin
        in_brk_q <= 1'b0;
      end
    end
  end

  // four separate level request lines and priority vector
  logic any_rx_en;
  assign any_rx_en = ctrl_q[RIE_B] | ctrl_q[RX_ERROR_IRQ_ENABLE_B];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_empty_irq <= 1'b0;
      rx_full_irq  <= 1'b0;
      break_irq    <= 1'b0;
      rx_error_irq <= 1'b0;
      ivec_q       <= IV_NONE;
    end else begin
      tx_empty_irq <= ctrl_q[TIE_B] & tx_fifo_empty_flag_q;
      rx_full_irq  <= ctrl_q[RIE_B] & (rdf_q | (rdy_q & ~ctrl_q[SYNC_B]));
      break_irq    <= any_rx_en & (brk_q | ovr_q);
      rx_error_irq <= any_rx_en & err_q;
      if (rx_error_irq)      ivec_q <= IV_ERR;
      else if (rx_full_irq)  ivec_q <= IV_RXF;
      else if (break_irq)    ivec_q <= IV_BRK;
      else if (tx_empty_irq) ivec_q <= IV_TXE;
      else                   ivec_q <= IV_NONE;
    end
  end

  // checks
  sequence tx_turn_on;
    $rose(tx_en) && tx_cnt_q != 5'h00;
  endsequence
  sequence rx_mid_low;
    rx_st_q == ST_START && tick && rx_sub_q == MID_TICK && !rx_s2_q && ctrl_q[RXEN_B];
  endsequence
  txe_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> tx_empty_irq == $past(ctrl_q[TIE_B] & tx_fifo_empty_flag_q))
    else $error("tx empty request wrong");
  rxf_async_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_q[SYNC_B] && !rdf_q |=> !rx_full_irq)
    else $error("ready flag raised request in sync mode");
  rxf_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q[RIE_B] |=> !rx_full_irq)
    else $error("rx full request without enable");
  brk_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    any_rx_en && (brk_q || ovr_q) |=> break_irq)
    else $error("break request missing");
  err_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> rx_error_irq == $past(any_rx_en & err_q))
    else $error("rx error request wrong");
  ivec_prio_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_error_irq |=> ivec_q == IV_ERR)
    else $error("priority vector wrong");
  tx_fifo_empty_flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_cnt_q <= tx_thr |=> tx_fifo_empty_flag_q)
    else $error("tx empty flag not set");
  rdf_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_cnt_q >= rx_thr |=> rdf_q)
    else $error("rx full flag not set");
  brk_nopush_a: assert property (@(posedge hclk) disable iff (!hresetn)
    in_brk_q |-> !rx_push)
    else $error("fifo written during break");
  txd_port_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !tx_en |=> txd_o == $past(port_q[TXLV_B]) && txd_oe == $past(port_q[TXOE_B]))
    else $error("txd not following port bits");
  start_now_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_turn_on ##1 tx_en |=> !txd_o)
    else $error("start bit late");
  rx_mid_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_mid_low |=> rx_st_q == ST_DATA && rx_sub_q == 4'h0)
    else $error("mid sample missed");
endmodule

// *** verification/fsp_remote.sv ***
// remote asynchronous transceiver model facing the serial port pins
`timescale 1ns/1ns
module fsp_remote #(
  parameter int BIT_CYC = 32
) (
  input  wire logic hclk,
  input  wire logic txd_o,
  input  wire logic txd_oe,
  output logic      rxd_i
);
  logic       line;
  logic [7:0] rx_byte;
  int         rx_count;

  // a released tx pin is pulled up to the mark level
  assign line = txd_oe ? txd_o : 1'b1;

  // receive line idles at mark
  initial begin
    rxd_i    = 1'b1;
    rx_byte  = 8'h00;
    rx_count = 0;
  end

  // one 8n1 frame, lsb first; a low stop bit makes a bad frame
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_i <= f[i];
      repeat (BIT_CYC) @(posedge hclk);
    end
    rxd_i <= 1'b1;
  endtask

  // hold the line low for a number of bit times
  task automatic break_flag(input int n);
    rxd_i <= 1'b0;
    repeat (n * BIT_CYC) @(posedge hclk);
    rxd_i <= 1'b1;
  endtask

  // sample tx frames mid bit; only frames with a high stop bit count
  always begin
    @(negedge line);
    repeat (BIT_CYC / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge hclk);
      rx_byte[i] = line;
    end
    repeat (BIT_CYC) @(posedge hclk);
    if (line === 1'b1) begin
      rx_count++;
    end
  end
endmodule

// *** verification/tb.sv ***
// self-checking bench for the fifo serial port
`timescale 1ns/1ns
module tb;
  import fsp_pkg::*;
  localparam int BIT_CYC = 32;  // baud value 1: base tick every 2 clocks
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  wire logic   hready;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rxd_i;
  logic        txd_o;
  logic        txd_oe;
  logic        rts_o;
  logic        rts_oe;
  logic        tx_empty_irq;
  logic        rx_error_irq;
  logic        rx_full_irq;
  logic        break_irq;
  int          err_count;
  int          cmp_count;
  int          c0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  fsp_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_i(rxd_i),
    .txd_o(txd_o), .txd_oe(txd_oe), .rts_o(rts_o), .rts_oe(rts_oe),
    .tx_empty_irq(tx_empty_irq), .rx_error_irq(rx_error_irq),
    .rx_full_irq(rx_full_irq), .break_irq(break_irq)
  );

  fsp_remote #(.BIT_CYC(BIT_CYC)) remote (
    .hclk(hclk), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd_i)
  );

  // 125 mhz clock
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  // verdict and end of run
  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // next edge with ready high, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask

  // one single ahb-lite word transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    hsel   <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp,
                      input logic [31:0] m);
    bus(a, 1'b0, 32'h0);
    chk(name, exp, rd & m);
  endtask

  // wait for the remote to take a good frame, bounded
  task automatic wait_tx(input int from);
    int n;
    n = 0;
    while (remote.rx_count == from && n < 20 * BIT_CYC) begin
      @(posedge hclk);
      n++;
    end
    if (remote.rx_count == from) begin
      err_count++;
      close_out();
    end
  endtask

  // main sequence
  initial begin
    err_count = 0;
    cmp_count = 0;
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    rd        = 32'h0;
    tick(2);
    hresetn <= 1'b1;
    tick(2);
    chk("txd_oe", 32'h0, 32'(txd_oe));
    chk("txd", 32'(PORT_RST[TXLV_B]), 32'(txd_o));
    chk("irq lines", 32'h0, 32'({tx_empty_irq, rx_error_irq, rx_full_irq, break_irq}));
    // transmit empty request and its re-setting flag
    wr(BAUD_OFS, 32'h1);
    wr(CTRL_OFS, 32'h80);
    tick(4);
    chk("tx_empty_irq", 32'h1, 32'(tx_empty_irq));
    chk("other irqs", 32'h0, 32'({rx_error_irq, rx_full_irq, break_irq}));
    rchk("vector", IVEC_OFS, 32'h4, 32'hFF);
    wr(STAT_OFS, 32'hDF);
    tick(4);
    rchk("tx empty flag", STAT_OFS, 32'h20, 32'h20);
    wr(CTRL_OFS, 32'h00);
    tick(4);
    chk("tx_empty_irq off", 32'h0, 32'(tx_empty_irq));
    // pin follows port bits while transmit is off
    wr(PORT_OFS, 32'h02);
    tick(2);
    chk("txd low", 32'h2, 32'({txd_oe, txd_o}));
    wr(PORT_OFS, 32'h03);
    tick(2);
    chk("txd mark", 32'h3, 32'({txd_oe, txd_o}));
    // one received byte against trigger 1
    wr(CTRL_OFS, 32'h50);
    remote.send(8'hA5, 1'b1);
    tick(2 * BIT_CYC);
    chk("rx_full_irq", 32'h1, 32'(rx_full_irq));
    rchk("count", CNT_OFS, 32'h0001, 32'hFFFF);
    rchk("vector", IVEC_OFS, 32'h2, 32'hFF);
    wr(STAT_OFS, 32'hFD);
    tick(4);
    rchk("rx full flag", STAT_OFS, 32'h02, 32'h02);
    rchk("rx data", RXD_OFS, 32'hA5, 32'hFF);
    wr(STAT_OFS, 32'h00);
    tick(4);
    chk("rx_full_irq off", 32'h0, 32'(rx_full_irq));
    // data ready below trigger 14, async then sync
    wr(FCR_OFS, 32'hC0);
    remote.send(8'h3C, 1'b1);
    tick(20 * BIT_CYC);
    chk("ready irq", 32'h1, 32'(rx_full_irq));
    wr(CTRL_OFS, 32'h51);
    tick(4);
    chk("ready irq sync", 32'h0, 32'(rx_full_irq));
    wr(CTRL_OFS, 32'h50);
    rchk("rx data", RXD_OFS, 32'h3C, 32'hFF);
    wr(STAT_OFS, 32'h00);
    // break with only the error enable set
    wr(CTRL_OFS, 32'h18);
    remote.break_flag(20);
    tick(2 * BIT_CYC);
    chk("break_irq", 32'h1, 32'(break_irq));
    chk("rx_error_irq", 32'h1, 32'(rx_error_irq));
    chk("rx_full_irq", 32'h0, 32'(rx_full_irq));
    rchk("framing flag", STAT_OFS, 32'h08, 32'h08);
    rchk("count", CNT_OFS, 32'h0, 32'hFF);
    rchk("vector", IVEC_OFS, 32'h1, 32'hFF);
    wr(STAT_OFS, 32'h00);
    wr(LINE_OFS, 32'h00);
    tick(4);
    chk("error irqs off", 32'h0, 32'({rx_error_irq, break_irq}));
    // transmit starts right after enable
    wr(CTRL_OFS, 32'h00);
    wr(TXD_OFS, 32'h5A);
    c0 = remote.rx_count;
    wr(CTRL_OFS, 32'h20);
    tick(4);
    chk("start bit", 32'h0, 32'(txd_o));
    wait_tx(c0);
    chk("tx byte", 32'h5A, 32'(remote.rx_byte));
    // break by dropping the level bit, then transmit enable, mid frame
    wr(TXD_OFS, 32'hFF);
    tick(3 * BIT_CYC);
    wr(PORT_OFS, 32'h02);
    wr(CTRL_OFS, 32'h00);
    tick(3);
    chk("break level", 32'h2, 32'({txd_oe, txd_o}));
    wr(PORT_OFS, 32'h00);
    tick(3);
    chk("txd float", 32'h0, 32'(txd_oe));
    chk("rts float", 32'h0, 32'(rts_oe));
    chk("rts level", 32'h0, 32'(rts_o));
    close_out();
  end
endmodule
